/* hw/exc_prio_defs.vh */
// Constants for the core exception prioritizer
// What this block does
// - Among pending causes only the highest ranked, reset first, is taken.
// - Reset exception, highest, on master clear or power-on reset.
// - Debug single-step exception ranks second, raised on single-step request.
// - Debug interrupt from external input or debug break-request bit.
// - Non-maskable interrupt exception on NMI assertion, below debug interrupt.
// - Interrupt exception only for an unmasked hardware or software request.
// - Instruction-break exception when instruction breakpoint compare matches.
// - Fetch address error on misaligned or protected fetch address.
// - Instruction bus error exception on bus error during fetch.
// - Debug breakpoint exception when software debug-break instruction executes.
// - System-call exception when the system-call instruction executes.
// - Break exception, below system call, when break instruction executes.
// - Reserved-instruction exception on a reserved encoding.
// - Coprocessor-unusable exception for an instruction to a disabled coprocessor.
// - Overflow exception when an overflow-checking arithmetic result overflows.
// - Trap exception only when trap instruction condition is true.
// - Data-break on address-only match or store address plus value match.
// - Load address error on misaligned or protected load address.
// - Store address error on misaligned or protected store address.
// - Data bus error exception on bus error for load or store.
// - Lowest ranked data breakpoint on loaded data compare match.
`ifndef EXC_PRIO_DEFS_VH
`define EXC_PRIO_DEFS_VH
`define CAUSE_COUNT 20
`define CAUSE_ID_WIDTH 5
`define SYNC_STAGES 2
`define CAUSE_RESET 5'h00
`define CAUSE_SINGLE_STEP 5'h01
`define CAUSE_DEBUG_INT 5'h02
`define CAUSE_NMI 5'h03
`define CAUSE_INTERRUPT 5'h04
`define CAUSE_INSTR_BREAK 5'h05
`define CAUSE_FETCH_ADDR 5'h06
`define CAUSE_FETCH_BUS 5'h07
`define CAUSE_DEBUG_BP 5'h08
`define CAUSE_SYSTEM_CALL_OP 5'h09
`define CAUSE_BREAK 5'h0a
`define CAUSE_RESERVED 5'h0b
`define CAUSE_COP_UNUSABLE 5'h0c
`define CAUSE_OVERFLOW 5'h0d
`define CAUSE_TRAP 5'h0e
`define CAUSE_DATA_BREAK 5'h0f
`define CAUSE_LOAD_ADDR 5'h10
`define CAUSE_STORE_ADDR 5'h11
`define CAUSE_DATA_BUS 5'h12
`define CAUSE_LOAD_DATA_BREAK 5'h13
`define CAUSE_NONE 5'h1f
`define SW_IRQ_COUNT 2
`endif

/* hw/sync_2ff.v */
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/10ps
`default_nettype none
module sync_2ff #(
  parameter WIDTH = 1
) (
  input wire clk,
  input wire rst,
  input wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : bitSync
      reg firstStage_reg;
      reg secondStage_reg;
      // First stage feeds only the second stage
      always @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          firstStage_reg <= 1'b0;
          secondStage_reg <= 1'b0;
        end
        else
        begin
          firstStage_reg <= asyncIn[i];
          secondStage_reg <= firstStage_reg;
        end
      end
      assign syncOut[i] = secondStage_reg;
    end
  endgenerate
endmodule
`default_nettype wire

/* hw/cause_priority_encoder.v */
// Fixed priority encoder, bit 0 ranks highest
`timescale 1ns/10ps
`default_nettype none
module cause_priority_encoder #(
  parameter WIDTH = 20,
  parameter ID_WIDTH = 5
) (
  input wire [WIDTH-1:0] causeVec,
  output wire anyCause,
  output wire [ID_WIDTH-1:0] winnerId
);
  wire [WIDTH:0] blocked;
  wire [ID_WIDTH-1:0] partialId [0:WIDTH];
  assign blocked[0] = 1'b0;
  assign partialId[0] = {ID_WIDTH{1'b0}};
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : rank
      localparam [31:0] RANK = i;
      // A cause wins only if nothing above it is pending
      assign blocked[i+1] = blocked[i] | causeVec[i];
      assign partialId[i+1] = (causeVec[i] & ~blocked[i]) ? RANK[ID_WIDTH-1:0] : partialId[i];
    end
  endgenerate
  assign anyCause = blocked[WIDTH];
  assign winnerId = partialId[WIDTH];
endmodule
`default_nettype wire

/* hw/core_exception_prioritizer.v */
// Core exception recognition and fixed-priority selection
`include "exc_prio_defs.vh"
`timescale 1ns/10ps
`default_nettype none
module core_exception_prioritizer #(
  parameter SW_IRQS = `SW_IRQ_COUNT
) (
  input wire clk,
  input wire rst,
  input wire masterClearPinN,
  input wire debugInterruptInput,
  input wire nmiPin,
  input wire debugSingleStep,
  input wire debugBreakRequestBit,
  input wire hwIrqReq,
  input wire hwIrqMasked,
  input wire [SW_IRQS-1:0] swIrqReq,
  input wire [SW_IRQS-1:0] swIrqMask,
  input wire irqGlobalEnable,
  input wire instructionBreakMatch,
  input wire fetchMisaligned,
  input wire fetchProtected,
  input wire instructionFetchBusFault,
  input wire softwareDebugBreakOp,
  input wire systemCallOp,
  input wire breakOp,
  input wire reservedOp,
  input wire copOp,
  input wire copEnabled,
  input wire arithmeticOverflow,
  input wire overflowCheckOp,
  input wire trapOp,
  input wire trapCondTrue,
  input wire dataAddrOnlyMatch,
  input wire storeOp,
  input wire storeAddrMatch,
  input wire storeValueMatch,
  input wire loadMisaligned,
  input wire loadProtected,
  input wire storeMisaligned,
  input wire storeProtected,
  input wire dataBusFault,
  input wire loadDataBreakMatch,
  input wire entryDone,
  output reg excTake,
  output reg [`CAUSE_ID_WIDTH-1:0] excCauseId,
  output reg excBusy,
  output reg inResetHold
);
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_TAKE = 3'b010;
  localparam [2:0] ST_WAIT = 3'b100;

  wire [2:0] pinSync;
  wire masterClearActive;
  wire debugIntLevel;
  wire nmiLevel;

  // Pins arrive from outside the clock domain
  sync_2ff #(
    .WIDTH(3)
  ) pinSyncInst (
    .clk(clk),
    .rst(rst),
    .asyncIn({nmiPin, debugInterruptInput, ~masterClearPinN}),
    .syncOut(pinSync)
  );
  assign masterClearActive = pinSync[0];
  assign debugIntLevel = pinSync[1];
  assign nmiLevel = pinSync[2];

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg resetPending_reg;
  reg resetPending_next;
  reg debugIntPrev_reg;
  reg debugIntPending_reg;
  reg debugIntPending_next;
  reg nmiPrev_reg;
  reg nmiPending_reg;
  reg nmiPending_next;
  reg excTake_next;
  reg [`CAUSE_ID_WIDTH-1:0] excCauseId_next;

  wire debugIntRise;
  wire nmiRise;
  wire irqActive;
  wire [`CAUSE_COUNT-1:0] causeVec;
  wire anyCause;
  wire [`CAUSE_ID_WIDTH-1:0] winnerId;
  wire takeNow;
  wire takenReset;
  wire takenDebugInt;
  wire takenNmi;

  // Edge-sensitive pin events are held until taken
  assign debugIntRise = debugIntLevel & ~debugIntPrev_reg;
  assign nmiRise = nmiLevel & ~nmiPrev_reg;

  // Any unmasked source with interrupts globally enabled
  assign irqActive = irqGlobalEnable & ((hwIrqReq & ~hwIrqMasked) | (|(swIrqReq & ~swIrqMask)));

  // Bit position equals rank; bit 0 is highest
  assign causeVec[`CAUSE_RESET] = resetPending_reg & ~masterClearActive;
  assign causeVec[`CAUSE_SINGLE_STEP] = debugSingleStep;
  assign causeVec[`CAUSE_DEBUG_INT] = debugIntPending_reg | debugBreakRequestBit;
  assign causeVec[`CAUSE_NMI] = nmiPending_reg;
  assign causeVec[`CAUSE_INTERRUPT] = irqActive;
  assign causeVec[`CAUSE_INSTR_BREAK] = instructionBreakMatch;
  assign causeVec[`CAUSE_FETCH_ADDR] = fetchMisaligned | fetchProtected;
  assign causeVec[`CAUSE_FETCH_BUS] = instructionFetchBusFault;
  assign causeVec[`CAUSE_DEBUG_BP] = softwareDebugBreakOp;
  assign causeVec[`CAUSE_SYSTEM_CALL_OP] = systemCallOp;
  assign causeVec[`CAUSE_BREAK] = breakOp;
  assign causeVec[`CAUSE_RESERVED] = reservedOp;
  assign causeVec[`CAUSE_COP_UNUSABLE] = copOp & ~copEnabled;
  assign causeVec[`CAUSE_OVERFLOW] = overflowCheckOp & arithmeticOverflow;
  assign causeVec[`CAUSE_TRAP] = trapOp & trapCondTrue;
  assign causeVec[`CAUSE_DATA_BREAK] = dataAddrOnlyMatch | (storeOp & storeAddrMatch & storeValueMatch);
  assign causeVec[`CAUSE_LOAD_ADDR] = loadMisaligned | loadProtected;
  assign causeVec[`CAUSE_STORE_ADDR] = storeMisaligned | storeProtected;
  assign causeVec[`CAUSE_DATA_BUS] = dataBusFault;
  assign causeVec[`CAUSE_LOAD_DATA_BREAK] = loadDataBreakMatch;

  cause_priority_encoder #(
    .WIDTH(`CAUSE_COUNT),
    .ID_WIDTH(`CAUSE_ID_WIDTH)
  ) prioInst (
    .causeVec(causeVec),
    .anyCause(anyCause),
    .winnerId(winnerId)
  );

  // Only one winner leaves per take; the rest wait
  assign takeNow = (state_reg == ST_IDLE) & anyCause;
  assign takenReset = takeNow & (winnerId == `CAUSE_RESET);
  assign takenDebugInt = takeNow & (winnerId == `CAUSE_DEBUG_INT);
  assign takenNmi = takeNow & (winnerId == `CAUSE_NMI);

  always @*
  begin
    // Set wins over the clear in the same cycle
    resetPending_next = resetPending_reg;
    if (takenReset)
      resetPending_next = 1'b0;
    if (masterClearActive)
      resetPending_next = 1'b1;
    debugIntPending_next = debugIntPending_reg;
    if (takenDebugInt)
      debugIntPending_next = 1'b0;
    if (debugIntRise)
      debugIntPending_next = 1'b1;
    nmiPending_next = nmiPending_reg;
    if (takenNmi)
      nmiPending_next = 1'b0;
    if (nmiRise)
      nmiPending_next = 1'b1;
  end

  always @*
  begin
    state_next = state_reg;
    excTake_next = 1'b0;
    excCauseId_next = excCauseId;
    case (state_reg)
      ST_IDLE:
      begin
        if (anyCause)
        begin
          excTake_next = 1'b1;
          excCauseId_next = winnerId;
          state_next = ST_TAKE;
        end
      end
      ST_TAKE:
      begin
        // Strobe lasts one cycle; the id stays until the next take
        if (entryDone)
          state_next = ST_IDLE;
        else
          state_next = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (entryDone)
          state_next = ST_IDLE;
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      // Power-on leaves a reset exception pending
      resetPending_reg <= 1'b1;
      debugIntPrev_reg <= 1'b0;
      debugIntPending_reg <= 1'b0;
      nmiPrev_reg <= 1'b0;
      nmiPending_reg <= 1'b0;
      excTake <= 1'b0;
      excCauseId <= `CAUSE_NONE;
      excBusy <= 1'b0;
      inResetHold <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      resetPending_reg <= resetPending_next;
      debugIntPrev_reg <= debugIntLevel;
      debugIntPending_reg <= debugIntPending_next;
      nmiPrev_reg <= nmiLevel;
      nmiPending_reg <= nmiPending_next;
      excTake <= excTake_next;
      excCauseId <= excCauseId_next;
      excBusy <= (state_next != ST_IDLE);
      inResetHold <= masterClearActive;
    end
  end
endmodule
`default_nettype wire

/* verification/core_exception_prioritizer_sva.sv */
// Assertion checker for the core exception prioritizer
`timescale 1ns/10ps
`default_nettype none
`include "exc_prio_defs.vh"
module exc_prio_checker (
  input wire clk,
  input wire rst,
  input wire excTake,
  input wire [4:0] excCauseId,
  input wire excBusy,
  input wire inResetHold,
  input wire entryDone,
  input wire systemCallOp,
  input wire breakOp,
  input wire trapOp,
  input wire trapCondTrue,
  input wire irqGlobalEnable,
  input wire overflowCheckOp,
  input wire arithmeticOverflow
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_take_pulse: assert property (excTake |=> !excTake)
    else $error("take held two cycles");
  a_busy_on_take: assert property (excTake |-> excBusy)
    else $error("take without busy");
  a_no_take_busy: assert property (excBusy && !entryDone |=> !excTake)
    else $error("take while busy");
  a_busy_release: assert property (excBusy && entryDone |=> !excBusy || excTake)
    else $error("busy not released");
  a_id_holds: assert property (!excTake |-> $stable(excCauseId))
    else $error("cause id moved without take");
  a_hold_no_take: assert property (inResetHold |-> !excTake)
    else $error("take during master clear");
  a_system_call_op_src: assert property (excTake && excCauseId == `CAUSE_SYSTEM_CALL_OP |-> $past(systemCallOp))
    else $error("system call id without request");
  a_break_rank: assert property (excTake && excCauseId == `CAUSE_BREAK |-> $past(breakOp) && !$past(systemCallOp))
    else $error("break taken over system call");
  a_trap_cond: assert property (excTake && excCauseId == `CAUSE_TRAP |-> $past(trapOp && trapCondTrue))
    else $error("trap without true condition");
  a_irq_enabled: assert property (excTake && excCauseId == `CAUSE_INTERRUPT |-> $past(irqGlobalEnable))
    else $error("interrupt taken while disabled");
  a_ovf_checked: assert property (excTake && excCauseId == `CAUSE_OVERFLOW |-> $past(overflowCheckOp && arithmeticOverflow))
    else $error("overflow without checked op");
endmodule
bind core_exception_prioritizer exc_prio_checker chk (.clk(clk), .rst(rst), .excTake(excTake),
  .excCauseId(excCauseId), .excBusy(excBusy), .inResetHold(inResetHold), .entryDone(entryDone),
  .systemCallOp(systemCallOp), .breakOp(breakOp), .trapOp(trapOp), .trapCondTrue(trapCondTrue),
  .irqGlobalEnable(irqGlobalEnable), .overflowCheckOp(overflowCheckOp), .arithmeticOverflow(arithmeticOverflow));
`default_nettype wire

/* verification/handler_entry_model.sv */
// Handler-entry responder that acknowledges each taken exception
`timescale 1ns/10ps
`default_nettype none
module handler_entry_model (
  input wire clk,
  input wire rst,
  input wire excTake,
  input wire [3:0] lag,
  output logic entryDone
);
  logic pend_reg;
  logic [3:0] cnt_reg;
  // Lag zero answers in the cycle right after the take; ST_TAKE would also accept an answer in the take cycle
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pend_reg <= 1'b0;
      cnt_reg <= 4'h0;
      entryDone <= 1'b0;
    end
    else
    begin
      entryDone <= 1'b0;
      if (excTake && lag == 4'h0)
        entryDone <= 1'b1;
      else if (excTake)
      begin
        pend_reg <= 1'b1;
        cnt_reg <= lag - 4'h1;
      end
      else if (pend_reg && cnt_reg != 4'h0)
        cnt_reg <= cnt_reg - 4'h1;
      else if (pend_reg)
      begin
        pend_reg <= 1'b0;
        entryDone <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* verification/core_exception_prioritizer_tb.sv */
// Self-checking testbench for the core exception prioritizer
`timescale 1ns/10ps
`default_nettype none
`include "exc_prio_defs.vh"
module core_exception_prioritizer_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic masterClearPinN = 1'b1;
  logic [34:0] v = '0;
  logic [3:0] lag = 4'h0;
  wire entryDone;
  wire excTake;
  wire [4:0] excCauseId;
  wire excBusy;
  wire inResetHold;
  int errors = 0;
  int nTests = 0;
  int cyc = 0;
  int i;
  // Three cause bits and the expected id; 31 means no take may happen
  int t[42][4] = '{'{0,0,0,1}, '{1,1,1,2}, '{2,2,2,2}, '{3,3,3,3},
    '{4,6,6,4}, '{31,6,6,4}, '{32,6,6,4}, '{4,5,6,31}, '{31,33,6,31}, '{32,34,6,31}, '{4,4,4,31},
    '{7,7,7,5}, '{8,8,8,6}, '{9,9,9,6}, '{10,10,10,7}, '{11,11,11,8},
    '{12,12,12,9}, '{13,13,13,10}, '{14,14,14,11}, '{15,15,15,12},
    '{15,16,16,31}, '{17,18,18,13}, '{17,17,17,31}, '{19,20,20,14}, '{19,19,19,31},
    '{21,21,21,15}, '{22,23,24,15}, '{22,23,23,31}, '{25,25,25,16}, '{26,26,26,16},
    '{27,27,27,17}, '{28,28,28,17}, '{29,29,29,18}, '{30,30,30,19},
    '{0,30,30,1}, '{4,6,29,4}, '{12,13,13,9}, '{8,10,10,6}, '{19,20,21,14},
    '{25,27,27,16}, '{2,4,6,2}, '{7,8,8,5}};
  core_exception_prioritizer #(.SW_IRQS(2)) dut (.clk(clk), .rst(rst), .masterClearPinN(masterClearPinN),
    .debugSingleStep(v[0]), .debugInterruptInput(v[1]), .debugBreakRequestBit(v[2]), .nmiPin(v[3]),
    .hwIrqReq(v[4]), .hwIrqMasked(v[5]), .irqGlobalEnable(v[6]), .instructionBreakMatch(v[7]),
    .fetchMisaligned(v[8]), .fetchProtected(v[9]), .instructionFetchBusFault(v[10]),
    .softwareDebugBreakOp(v[11]), .systemCallOp(v[12]), .breakOp(v[13]), .reservedOp(v[14]), .copOp(v[15]),
    .copEnabled(v[16]), .arithmeticOverflow(v[17]), .overflowCheckOp(v[18]), .trapOp(v[19]),
    .trapCondTrue(v[20]), .dataAddrOnlyMatch(v[21]), .storeOp(v[22]), .storeAddrMatch(v[23]),
    .storeValueMatch(v[24]), .loadMisaligned(v[25]), .loadProtected(v[26]), .storeMisaligned(v[27]),
    .storeProtected(v[28]), .dataBusFault(v[29]), .loadDataBreakMatch(v[30]), .swIrqReq(v[32:31]),
    .swIrqMask(v[34:33]), .entryDone(entryDone), .excTake(excTake), .excCauseId(excCauseId),
    .excBusy(excBusy), .inResetHold(inResetHold));
  handler_entry_model partner (.clk(clk), .rst(rst), .excTake(excTake), .lag(lag), .entryDone(entryDone));
  always #25 clk = ~clk;
  task print_verdict();
    if (errors == 0 && nTests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chkBit(input logic got, input logic exp, input string what);
    nTests++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask
  task chkId(input logic [4:0] got, input logic [4:0] exp);
    nTests++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t cause id %h, expected %h", $time, got, exp);
    end
  endtask
  // Pin causes pass a synchroniser, so the wait bound covers that latency
  task automatic waitTake(input int lim);
    int k;
    k = 0;
    while (excTake !== 1'b1 && k < lim)
    begin
      @(posedge clk);
      #1 k++;
    end
  endtask
  task automatic waitIdle();
    int k;
    k = 0;
    while (excBusy !== 1'b0 && k < 20)
    begin
      @(posedge clk);
      #1 k++;
    end
    chkBit(excBusy, 1'b0, "busy stuck");
  endtask
  task automatic fire(input int a, input int b, input int c, input logic [4:0] id);
    @(posedge clk);
    #1 v = (35'h1 << a) | (35'h1 << b) | (35'h1 << c);
    waitTake(8);
    chkBit(excTake, id !== `CAUSE_NONE, "take presence");
    if (id !== `CAUSE_NONE)
      chkId(excCauseId, id);
    v = '0;
    waitIdle();
  endtask
  task do_reset();
    rst = 1'b1;
    repeat (4) @(posedge clk);
    #1 chkId(excCauseId, `CAUSE_NONE);
    rst = 1'b0;
    waitTake(4);
    chkBit(excTake, 1'b1, "no power-on take");
    chkId(excCauseId, `CAUSE_RESET);
    waitIdle();
  endtask
  task back_to_back();
    lag = 4'h0;
    @(posedge clk);
    #1 v = (35'h1 << 12) | (35'h1 << 13);
    waitTake(4);
    chkId(excCauseId, `CAUSE_SYSTEM_CALL_OP);
    v[12] = 1'b0;
    // Busy drops one edge after the answer, the next take one edge later
    repeat (3) @(posedge clk);
    #1 chkBit(excTake, 1'b1, "no second take");
    chkId(excCauseId, `CAUSE_BREAK);
    v = '0;
    waitIdle();
  endtask
  task master_clear_pin_hold();
    @(posedge clk);
    #1 masterClearPinN = 1'b0;
    repeat (6) @(posedge clk);
    #1 chkBit(inResetHold, 1'b1, "clear not held");
    masterClearPinN = 1'b1;
    waitTake(8);
    chkBit(excTake, 1'b1, "no clear take");
    chkId(excCauseId, `CAUSE_RESET);
    waitIdle();
  endtask
  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      errors++;
      print_verdict();
    end
  end
  initial
  begin
    do_reset();
    for (i = 0; i < 42; i++)
    begin
      lag = 4'(i % 3 * 2);
      fire(t[i][0], t[i][1], t[i][2], 5'(t[i][3]));
    end
    back_to_back();
    master_clear_pin_hold();
    do_reset();
    print_verdict();
  end
endmodule
`default_nettype wire
